// [hw/ctpwm_params.svh]
/*
 * Constants for the compare-table pulse-width generator: table size,
 * command code layout, flush bit position and the state-time divider.
 * Assumes inclusion by bare name from the package; the design modules do not include it.
 */
`ifndef CTPWM_PARAMS_SVH
`define CTPWM_PARAMS_SVH

`define CTP_ENTRIES      8
`define CTP_CHANNELS     4
`define CTP_TIME_W       16
`define CTP_CODE_W       8
`define CTP_IOC_W        8
`define CTP_FLUSH_BIT    7
`define CTP_STATE_DIV    2
`define CTP_TGT_PAIR_LO  4'h6
`define CTP_TGT_PAIR_HI  4'h7
`define CTP_TGT_AUX_RST  4'he
`define CTP_TGT_ALL      4'hf
`define CTP_PIN_IDLE     1'b1

`endif

// [hw/ctpwm_pkg.sv]
/*
 * Types for the compare-table pulse-width generator.
 * Assumes ctpwm_params.svh is on the include path.
 */
`include "ctpwm_params.svh"

package ctpwm_pkg;

    typedef logic [`CTP_TIME_W-1:0] ctpwm_time_t;

    // code byte: lock, timer select, level, interrupt, target
    typedef struct packed {
        logic       lock;
        logic       useAux;
        logic       driveHigh;
        logic       irq;
        logic [3:0] target;
    } ctpwm_code_s;

    typedef struct packed {
        logic        valid;
        ctpwm_code_s code;
        ctpwm_time_t matchTime;
    } ctpwm_entry_s;

endpackage

// [hw/ctpwm_aux_if.sv]
/*
 * Link between the table logic and the auxiliary timer.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ns

interface ctpwm_aux_if
    import ctpwm_pkg::*;
();
    ctpwm_time_t count;
    logic        step;
    logic        resetReq;
    logic        clearReq;

    modport timer (output count, output step, input resetReq, input clearReq);
    modport user  (input count, input step, output resetReq, output clearReq);
endinterface

// [hw/ctpwm_aux_timer.sv]
/*
 * Auxiliary timer stepped by both edges of an external count pin.
 * Assumes the pin is asynchronous to core_clk; it is synchronised here.
 */
`timescale 1ns/1ns

module ctpwm_aux_timer
    import ctpwm_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    reset_n,
    input  wire logic    countPin,
    ctpwm_aux_if.timer   aux
);
    logic pinMeta;
    logic pinSync;
    logic pinLast;
    logic pinEdge;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
        end
        else
        begin
            pinMeta <= countPin;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    assign pinEdge = pinSync ^ pinLast;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            aux.count <= '0;
        else if (aux.resetReq || aux.clearReq)
            aux.count <= '0;
        else if (pinEdge)
            aux.count <= aux.count + 1'b1;
    end

    // step marks the cycle in which count holds a freshly taken value
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            aux.step <= 1'b0;
        else
            aux.step <= aux.resetReq || aux.clearReq || pinEdge;
    end

    both_edge_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pinEdge && !aux.resetReq && !aux.clearReq
        |=> aux.step && aux.count == $past(aux.count) + 1'b1)
        else $error("edge of count pin did not step the auxiliary timer");
endmodule

// [hw/ctpwm_top.sv]
/*
 * Compare-table pulse-width generator: eight timed commands matched against
 * a main timer or an externally stepped auxiliary timer, driving four outputs.
 * Assumes commands and flush come from control logic on core_clk and the
 * count pin is asynchronous.
 */
`timescale 1ns/1ns

// How it works
// - Up to four pulse-width outputs run independently at once.
// - Each command holds a time and action; fires when selected timer matches it.
// - Compare table holds at most eight pending commands.
// - Locked commands stay in the table after firing and repeat every pass.
// - Auxiliary-timer reset command at a match value sets the common period.
// - One command drives all outputs high; per-channel commands drive them low.
// - Auxiliary timer counts on both edges of its outside count input.
// - Flush bit seven of io control two empties table, locked entries too.
// - A command whose time has passed waits for the timer to come round.
// - Outputs idle high; a low level powers the motor.
module ctpwm_top
    import ctpwm_pkg::*;
#(
    parameter int ENTRIES   = `CTP_ENTRIES,
    parameter int CHANNELS  = `CTP_CHANNELS,
    parameter int STATE_DIV = `CTP_STATE_DIV
)
(
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   cmdValid,
    output logic                        cmdReady,
    input  wire logic [`CTP_CODE_W-1:0] cmdCode,
    input  wire ctpwm_time_t            cmdTime,
    input  wire logic [`CTP_IOC_W-1:0]  ioControlTwo,
    input  wire logic                   ioControlTwoWrite,
    input  wire logic                   auxCountPin,
    input  wire logic                   auxClear,
    output ctpwm_time_t                 auxTimerValue,
    output ctpwm_time_t                 mainTimerValue,
    output logic [3:0]                  pendingCount,
    output logic                        matchEvent,
    output logic [CHANNELS-1:0]         pwmOut
);
    localparam int IDX_W = $clog2(ENTRIES);

    ctpwm_aux_if auxLink ();

    ctpwm_entry_s               slot [ENTRIES];
    logic [ENTRIES-1:0]         fire;
    logic [ENTRIES-1:0]         validVec;
    logic [IDX_W-1:0]           freeIdx;
    logic                       hasFree;
    logic                       flush;
    logic                       doWrite;
    logic                       stateTick;
    logic [7:0]                 divCount;
    logic                       mainStep;
    logic [CHANNELS-1:0]        setMask;
    logic [CHANNELS-1:0]        clrMask;
    logic                       auxResetFire;
    logic                       irqFire;

    ctpwm_aux_timer auxTimer (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .countPin (auxCountPin),
        .aux      (auxLink.timer)
    );

    function automatic logic [CHANNELS-1:0] targetMask(input logic [3:0] target);
        logic [CHANNELS-1:0] m;
        m = '0;
        if (target == `CTP_TGT_ALL)
            m = '1;
        else if (target == `CTP_TGT_PAIR_LO)
            m = CHANNELS'(4'h3);
        else if (target == `CTP_TGT_PAIR_HI)
            m = CHANNELS'(4'hc);
        else if (target < 4'(CHANNELS))
            m[target[1:0]] = 1'b1;
        return m;
    endfunction

    // state-time enable from the core clock
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || stateTick)
            divCount <= '0;
        else
            divCount <= divCount + 1'b1;
    end
    assign stateTick = (divCount == 8'(STATE_DIV - 1));

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            mainTimerValue <= '0;
        else if (stateTick)
            mainTimerValue <= mainTimerValue + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            mainStep <= 1'b0;
        else
            mainStep <= stateTick;
    end

    assign flush   = ioControlTwoWrite && ioControlTwo[`CTP_FLUSH_BIT];
    assign cmdReady = hasFree && !flush;
    assign doWrite  = cmdValid && cmdReady;

    // lowest empty slot takes the next command
    always_comb
    begin
        hasFree = 1'b0;
        freeIdx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
            if (!slot[i].valid)
            begin
                hasFree = 1'b1;
                freeIdx = IDX_W'(i);
            end
        end
    end

    // compare only when the timer has just taken a new value, so a time already
    // passed waits for the next pass
    generate
        for (genvar g = 0; g < ENTRIES; g++)
        begin : gEntry
            assign validVec[g] = slot[g].valid;
            assign fire[g] = slot[g].valid && (slot[g].code.useAux
                ? (auxLink.step && auxLink.count == slot[g].matchTime)
                : (mainStep && mainTimerValue == slot[g].matchTime));

            always_ff @(posedge core_clk)
            begin
                if (!reset_n || flush)
                    slot[g].valid <= 1'b0;
                else if (doWrite && freeIdx == IDX_W'(g))
                    slot[g] <= {1'b1, ctpwm_code_s'(cmdCode), cmdTime};
                else if (fire[g] && !slot[g].code.lock)
                    slot[g].valid <= 1'b0;
            end

            unlocked_retire_a: assert property (@(posedge core_clk) disable iff (!reset_n)
                fire[g] && !slot[g].code.lock |=> !slot[g].valid)
                else $error("unlocked command stayed after firing");
            locked_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
                fire[g] && slot[g].code.lock && !flush |=> slot[g].valid)
                else $error("locked command left the table after firing");
        end
    endgenerate

    // gather actions of all entries firing this cycle
    always_comb
    begin
        setMask      = '0;
        clrMask      = '0;
        auxResetFire = 1'b0;
        irqFire      = 1'b0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (fire[i])
            begin
                irqFire = irqFire || slot[i].code.irq;
                if (slot[i].code.target == `CTP_TGT_AUX_RST)
                begin
                    auxResetFire = 1'b1;
                    irqFire      = 1'b1;
                end
                else if (slot[i].code.driveHigh)
                    setMask = setMask | targetMask(slot[i].code.target);
                else
                    clrMask = clrMask | targetMask(slot[i].code.target);
            end
        end
    end

    assign auxLink.resetReq = auxResetFire;
    assign auxLink.clearReq = auxClear;
    assign auxTimerValue    = auxLink.count;

    // each channel keeps its own level; a low that coincides with the high wins
    generate
        for (genvar c = 0; c < CHANNELS; c++)
        begin : gChan
            always_ff @(posedge core_clk)
            begin
                if (!reset_n)
                    pwmOut[c] <= `CTP_PIN_IDLE;
                else if (clrMask[c])
                    pwmOut[c] <= 1'b0;
                else if (setMask[c])
                    pwmOut[c] <= 1'b1;
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            matchEvent <= 1'b0;
        else
            matchEvent <= irqFire;
    end

    assign pendingCount = 4'($countones(validVec));

    sequence flushWrite;
        ioControlTwoWrite && ioControlTwo[`CTP_FLUSH_BIT];
    endsequence

    sequence tableEmpty;
        pendingCount == 4'h0;
    endsequence

    flush_clears_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        flushWrite |=> tableEmpty ##1 pendingCount <= 4'h1)
        else $error("flush left commands in the table");
    table_limit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pendingCount <= 4'(ENTRIES) && (pendingCount != 4'(ENTRIES) || !cmdReady))
        else $error("compare table exceeded its depth");
    aux_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        auxResetFire |=> auxTimerValue == '0 && matchEvent)
        else $error("reset command did not clear the auxiliary timer");
    low_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clrMask[0] |=> !pwmOut[0])
        else $error("drive-low command did not lower the output");
    set_high_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        setMask[0] && !clrMask[0] && auxResetFire |=> pwmOut[0] && auxTimerValue == '0)
        else $error("restart with outputs high did not happen together");
    idle_high_a: assert property (@(posedge core_clk)
        !reset_n |=> pwmOut == '1)
        else $error("outputs not idle high after reset");
endmodule

// [bench/ctpwm_stage_model.sv]
/*
 * Power stage model: one half bridge per channel, measuring low pulses of channel zero,
 * with a stall check on channel zero that counts over-limit samples.
 * Assumes pwmOut comes from registers on core_clk.
 */
`timescale 1ns/1ns

module ctpwm_stage_model
(
    input  wire logic        core_clk,
    input  wire logic [3:0]  pwmOut,
    output logic [3:0]       motorOn,
    output logic [15:0]      lastWidth,
    output logic             highCurrent
);
    logic [15:0] width;
    logic        convBusy;
    logic [4:0]  overCount;

    // a low level powers the motor
    assign motorOn = ~pwmOut;

    initial width = 16'h0000;
    initial lastWidth = 16'h0000;
    initial convBusy = 1'b0;
    initial overCount = 5'h00;

    // channel zero powered for 30 samples in a row stands for a stalled motor drawing too much current
    assign highCurrent = (overCount == 5'd30);

    always @(posedge core_clk)
    begin
        if (convBusy)
            convBusy <= 1'b0;
        else
        begin
            if (!motorOn[0])
                overCount <= 5'h00;
            else if (overCount != 5'd30)
                overCount <= overCount + 5'h01;
            convBusy <= 1'b1;
        end
    end

    // powered time of channel zero, latched when it turns off again
    always @(posedge core_clk)
    begin
        if (motorOn[0])
            width <= width + 16'h0001;
        else if (width != 16'h0000)
        begin
            lastWidth <= width;
            width <= 16'h0000;
        end
    end
endmodule

// [bench/testbench.sv]
/*
 * Self-checking bench for the compare-table pulse-width generator.
 * Assumes the design defaults with STATE_DIV 2, so a state time is 8 ns.
 */
`timescale 1ns/1ns

module testbench
    import ctpwm_pkg::*;
;
    logic        core_clk = 0;
    logic        reset_n = 0;
    logic        cmdValid = 0;
    logic        cmdReady;
    logic [7:0]  cmdCode = 8'h00;
    ctpwm_time_t cmdTime = 16'h0000;
    logic [7:0]  ioControlTwo = 8'h00;
    logic        ioControlTwoWrite = 0;
    logic        auxCountPin = 0;
    logic        auxClear = 0;
    ctpwm_time_t auxTimerValue;
    ctpwm_time_t mainTimerValue;
    logic [3:0]  pendingCount;
    logic        matchEvent;
    logic [3:0]  pwmOut;
    logic [3:0]  motorOn;
    logic [15:0] lastWidth;
    logic        highCurrent;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          events = 0;
    ctpwm_time_t t;

    always #2 core_clk = ~core_clk;

    ctpwm_top DUT (.core_clk(core_clk), .reset_n(reset_n), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdTime(cmdTime),
        .ioControlTwo(ioControlTwo), .ioControlTwoWrite(ioControlTwoWrite),
        .auxCountPin(auxCountPin), .auxClear(auxClear), .auxTimerValue(auxTimerValue),
        .mainTimerValue(mainTimerValue), .pendingCount(pendingCount),
        .matchEvent(matchEvent), .pwmOut(pwmOut));

    ctpwm_stage_model stage (.core_clk(core_clk), .pwmOut(pwmOut), .motorOn(motorOn),
        .lastWidth(lastWidth), .highCurrent(highCurrent));

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] code, input ctpwm_time_t tm);
        cmdValid = 1;
        cmdCode = code;
        cmdTime = tm;
        while (cmdReady !== 1'b1)
            tick();
        tick();
        cmdValid = 0;
        tick();
    endtask

    // one pin edge, then eight state times before the next one
    task automatic steps(input int n);
        repeat (n)
        begin
            auxCountPin = ~auxCountPin;
            repeat (16)
            begin
                tick();
                if (matchEvent === 1'b1)
                    events++;
            end
        end
    endtask

    task automatic ioc(input logic [7:0] v);
        ioControlTwo = v;
        ioControlTwoWrite = 1;
        tick();
        ioControlTwoWrite = 0;
        tick();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        end_of_test();
    end

    initial
    begin
        repeat (4) tick();
        reset_n = 1;
        chk("pwm idle", pwmOut, 16'hf);
        chk("pending", pendingCount, 16'h0);
        chk("ready", cmdReady, 16'h1);
        $display("test reset done");
        // reference setup: period 31, channel a low at 10, channel b low at 20
        send(8'hce, 16'd31);
        send(8'he6, 16'd31);
        send(8'hc0, 16'd10);
        send(8'hc1, 16'd20);
        chk("pending", pendingCount, 16'h4);
        steps(10);
        chk("pwm a low", pwmOut, 16'he);
        chk("stall early", highCurrent, 16'h0);
        steps(10);
        chk("pwm b low", pwmOut, 16'hc);
        chk("stall", highCurrent, 16'h1);
        steps(10);
        chk("aux", auxTimerValue, 16'd30);
        chk("event", 16'(events), 16'h0);
        steps(1);
        chk("event", 16'(events), 16'h1);
        chk("aux wrap", auxTimerValue, 16'h0);
        chk("pwm high", pwmOut, 16'hf);
        chk("stall gone", highCurrent, 16'h0);
        chk("locked", pendingCount, 16'h4);
        chk("duty", lastWidth, 16'd336);
        steps(10);
        chk("pwm a again", pwmOut, 16'he);
        $display("test locked pwm done");
        repeat (4) send(8'h02, 16'hff00);
        chk("full", pendingCount, 16'h8);
        chk("refuse", cmdReady, 16'h0);
        ioc(8'h40);
        chk("no flush", pendingCount, 16'h8);
        ioc(8'h80);
        chk("flushed", pendingCount, 16'h0);
        $display("test flush done");
        steps(2);
        chk("aux", auxTimerValue, 16'd12);
        send(8'hce, 16'd31);
        send(8'he6, 16'd31);
        send(8'h42, 16'd5);
        steps(19);
        chk("passed wait", pwmOut, 16'hf);
        steps(5);
        chk("late fire", pwmOut, 16'hb);
        chk("unlocked gone", pendingCount, 16'h2);
        $display("test passed time done");
        t = mainTimerValue + 16'h0010;
        send(8'h17, t);
        for (int i = 0; i < 100 && pwmOut[3] !== 1'b0; i++)
            tick();
        chk("main fire", pwmOut, 16'h3);
        chk("main event", matchEvent, 16'h1);
        chk("main time", 16'(mainTimerValue - t) < 16'h2, 16'h1);
        auxClear = 1;
        tick();
        auxClear = 0;
        tick();
        chk("aux clear", auxTimerValue, 16'h0);
        t = mainTimerValue + 16'h0004;
        send(8'h2f, t);
        for (int i = 0; i < 100 && pwmOut !== 4'hf; i++)
            tick();
        chk("all high", pwmOut, 16'hf);
        $display("test main timer done");
        end_of_test();
    end
endmodule
